// ===== include/pidp_pkg.sv
// How it works
// [RULE1] transceiver read data reaches the user read-data output unregistered and unchanged
// [RULE2] user read-ready mirrors the transceiver port ready, marking read data valid
// [RULE3] port-busy is high whenever the configuration port is not the user's
// [RULE4] user raises access request to ask for the configuration port
// [RULE5] a 5-bit phase step word goes to the interpolator step input each update
// [RULE6] drive port enable, write enable, 9-bit address, 16-bit data; accept ready, data
// [RULE7] detector result is shown as a 21-bit signed debug output
// [RULE8] loop filter output (control voltage) is shown as 22-bit signed
// [RULE9] 8-bit accumulator value plus accumulator and filter/converter strobes are shown
// [RULE10] each loop strobe loads detector error into filter, clears detector; strobe shown
// [RULE11] four flags: detector overflow, filter input, integrator, output saturation
// [RULE12] user keeps proportional gain between zero and 0x12
// [RULE13] user keeps integral gain between zero and 0x14
// [RULE14] reference divided by its 16-bit setting plus two
// [RULE15] transmit clock divided by the 16-bit local setting plus two
// [RULE16] 4-bit interpolator step size 1 to 15; zero gives no step
// [RULE17] loop strobe comes from a 16-bit rate setting, default 0x07ff
// [RULE18] user holds both divider enables high for normal operation
// [RULE19] offset-override enable replaces filter output with the direct offset input
// [RULE20] freeze stops filter output updates, keeping the last value
// [RULE21] gains act as two to the set value; integral gain best at least 1
// [RULE22] user ties the reserved 8-bit and 10-bit inputs to zero
// [RULE23] reset held eight cycles; first detector error and interpolator word are zero
// [RULE24] arbiter reset resets only the arbiter, loop keeps running
// [RULE25] user holds request until busy low; on release device regains port, busy high
// [RULE26] detector runs in freeze and override; override end shows live filter value
// [RULE27] divided reference event is synchronised into the transmit clock domain
package pidp_pkg;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam int ERR_W = 21;
   localparam int VOLT_W = 22;
   localparam int ACC_W = 8;
   localparam int STEP_W = 5;
   localparam int SIZE_W = 4;
   localparam int GAIN_W = 5;
   localparam int DIV_W = 16;
   localparam int RSVD_C_W = 8;
   localparam int RSVD_PN_W = 10;
   localparam logic [GAIN_W-1:0] G1_MAX = 5'h12;
   localparam logic [GAIN_W-1:0] G2_MAX = 5'h14;
   localparam logic [DIV_W-1:0] RATE_DEF = 16'h07ff;
   localparam logic [2:0] PI_DIV = 3'h6;
   localparam int WIDE_W = 48;
   localparam int AB_W = 40;
   localparam int INT_W = 40;
   localparam int FILT_SHIFT = 18;
   localparam int SD_W = 23;
   localparam logic signed [WIDE_W-1:0] SD_HALF = 48'sh200000;
   localparam logic signed [WIDE_W-1:0] SD_FULL = 48'sh400000;
   localparam logic [ADDR_W-1:0] PI_ADDR_DEF = 9'h000;

   typedef enum logic [1:0] {ARB_OWN, ARB_DRAIN, ARB_USER} pidp_arb_state_type;

   // saturation to the full two's-complement w-bit signed range
   function automatic logic signed [WIDE_W-1:0] pidp_clamp(
      input logic signed [WIDE_W-1:0] v,
      input int                       w);
      logic signed [WIDE_W-1:0] hi;
      hi = (48'sh1 <<< (w - 1)) - 48'sh1;
      if (v > hi) return hi;
      else if (v < -hi - 48'sh1) return -hi - 48'sh1;
      else return v;
   endfunction

   // terminal count of a divide-by-(setting+2) counter
   function automatic logic pidp_div_end(
      input logic [DIV_W:0]   cnt,
      input logic [DIV_W-1:0] setting);
      return cnt == {1'b0, setting} + 17'h1;
   endfunction
endpackage // pidp_pkg

// ===== include/pidp_cfg_if.sv
// device-side write requests toward the configuration port arbiter
interface pidp_cfg_if;
   import pidp_pkg::*;
   logic              req;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              grant;
   modport loop (output req, output addr, output wdata, input grant);
   modport arb (input req, input addr, input wdata, output grant);
endinterface // pidp_cfg_if

// ===== src/pidp_arbiter.sv
module pidp_arbiter (
   input  logic                          mclk,
   input  logic                          rst_n,
   input  logic                          ce,
   input  logic                          arb_reset,
   input  logic                          access_req,
   input  logic                          user_port_enable,
   input  logic                          user_port_write,
   input  logic [pidp_pkg::ADDR_W-1:0]   user_port_addr,
   input  logic [pidp_pkg::DATA_W-1:0]   user_port_wdata,
   input  logic                          cfg_port_ready_in,
   output logic                          cfg_port_enable_out,
   output logic                          cfg_port_write_out,
   output logic [pidp_pkg::ADDR_W-1:0]   cfg_port_addr_out,
   output logic [pidp_pkg::DATA_W-1:0]   cfg_port_wdata_out,
   output logic                          port_busy_out,
   pidp_cfg_if.arb                       dev
);
   import pidp_pkg::*;
   pidp_arb_state_type state_r, state_nxt;
   logic              pend_r, busy_r, en_r, we_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] data_r;
   logic              arb_clr, dev_issue, user_sel;

   // the loop writes only while it owns the port and nothing is outstanding
   assign arb_clr = !rst_n || arb_reset; // see [RULE24]
   assign dev.grant = (state_r == ARB_OWN) && !pend_r;
   assign dev_issue = dev.req && dev.grant;
   assign user_sel = state_r == ARB_USER;

   // a pending loop write must finish before the user gets the port
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ARB_OWN: if (access_req) state_nxt = ARB_DRAIN; // see [RULE4]
         ARB_DRAIN: begin
            if (!access_req) state_nxt = ARB_OWN;
            else if (!pend_r) state_nxt = ARB_USER;
         end
         ARB_USER: if (!access_req) state_nxt = ARB_OWN; // see [RULE25]
         default: state_nxt = ARB_OWN;
      endcase
   end

   // state, busy and outstanding-write tracking
   always_ff @(posedge mclk) begin
      if (arb_clr) begin
         state_r <= ARB_OWN;
         busy_r <= 1'b1;
         pend_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         busy_r <= state_nxt != ARB_USER; // see [RULE3]
         pend_r <= dev_issue || (pend_r && !cfg_port_ready_in);
      end
   end

   // port drive: user strobes pass one cycle late once granted
   always_ff @(posedge mclk) begin
      if (arb_clr) begin
         en_r <= 1'b0;
         we_r <= 1'b0;
         addr_r <= '0;
         data_r <= '0;
      end else if (ce) begin
         en_r <= user_sel ? user_port_enable : dev_issue; // see [RULE6]
         we_r <= user_sel ? user_port_write : dev_issue;
         addr_r <= user_sel ? user_port_addr : dev.addr;
         data_r <= user_sel ? user_port_wdata : dev.wdata;
      end
   end

   assign cfg_port_enable_out = en_r;
   assign cfg_port_write_out = we_r;
   assign cfg_port_addr_out = addr_r;
   assign cfg_port_wdata_out = data_r;
   assign port_busy_out = busy_r;

   property p_release_busy;
      @(posedge mclk) disable iff (!rst_n)
      (ce && !arb_reset && !access_req && !port_busy_out) |=> port_busy_out;
   endproperty
   a_release_busy: assert property (p_release_busy) // see [RULE25]
      else $error("busy did not rise after request removal");

   // the loop may issue its own write right after the reset; the user may not
   property p_arb_reset;
      @(posedge mclk) disable iff (!rst_n)
      arb_reset |=> port_busy_out && !cfg_port_enable_out
         ##1 port_busy_out && (!cfg_port_enable_out || $past(dev_issue));
   endproperty
   a_arb_reset: assert property (p_arb_reset) // see [RULE24]
      else $error("arbiter reset did not take the port back");

   property p_user_pass;
      @(posedge mclk) disable iff (!rst_n)
      (ce && !arb_reset && user_port_enable && !port_busy_out)
         |=> cfg_port_enable_out && cfg_port_addr_out == $past(user_port_addr);
   endproperty
   a_user_pass: assert property (p_user_pass) // see [RULE6]
      else $error("granted user access not forwarded");
endmodule // pidp_arbiter

// ===== src/pidp_top.sv
// The address map and the strobed register port are this design's own decisions.
module pidp_top #(
   parameter logic [pidp_pkg::ADDR_W-1:0] PI_ADDR = pidp_pkg::PI_ADDR_DEF
) (
   input  logic                                 mclk,
   input  logic                                 rst_n,
   input  logic                                 ce,
   input  logic                                 ref_clk_in,
   input  logic                                 arb_reset,
   input  logic                                 access_req,
   input  logic                                 user_port_enable,
   input  logic                                 user_port_write,
   input  logic [pidp_pkg::ADDR_W-1:0]          user_port_addr,
   input  logic [pidp_pkg::DATA_W-1:0]          user_port_wdata,
   output logic                                 user_read_ready,
   output logic [pidp_pkg::DATA_W-1:0]          user_read_data,
   output logic                                 port_busy_out,
   output logic                                 cfg_port_enable_out,
   output logic                                 cfg_port_write_out,
   output logic [pidp_pkg::ADDR_W-1:0]          cfg_port_addr_out,
   output logic [pidp_pkg::DATA_W-1:0]          cfg_port_wdata_out,
   input  logic [pidp_pkg::DATA_W-1:0]          cfg_port_rdata_in,
   input  logic                                 cfg_port_ready_in,
   output logic [pidp_pkg::STEP_W-1:0]          phase_step_out,
   output logic signed [pidp_pkg::ERR_W-1:0]    error_out,
   output logic signed [pidp_pkg::VOLT_W-1:0]   volt_out,
   output logic [pidp_pkg::ACC_W-1:0]           accumulator_value_out,
   output logic                                 accumulator_strobe_out,
   output logic                                 filter_dac_strobe_out,
   output logic                                 loop_strobe_out,
   output logic                                 detector_overflow_flag,
   output logic                                 filter_input_sat_flag,
   output logic                                 integrator_sat_flag,
   output logic                                 filter_output_sat_flag,
   input  logic [pidp_pkg::GAIN_W-1:0]          proportional_gain,
   input  logic [pidp_pkg::GAIN_W-1:0]          integral_gain,
   input  logic [pidp_pkg::DIV_W-1:0]           ref_div_setting,
   input  logic [pidp_pkg::DIV_W-1:0]           local_div_setting,
   input  logic [pidp_pkg::SIZE_W-1:0]          interp_step_size,
   input  logic [pidp_pkg::DIV_W-1:0]           loop_rate_setting,
   input  logic                                 local_divider_enable,
   input  logic                                 reference_divider_enable,
   input  logic [pidp_pkg::RSVD_C_W-1:0]        rsvd_c_in,
   input  logic [pidp_pkg::RSVD_PN_W-1:0]       rsvd_p_in,
   input  logic [pidp_pkg::RSVD_PN_W-1:0]       rsvd_n_in,
   input  logic signed [pidp_pkg::VOLT_W-1:0]   offset_value,
   input  logic                                 offset_enable,
   input  logic                                 freeze
);
   import pidp_pkg::*;
   pidp_cfg_if dev_if ();

   logic                     ref_s1_r, ref_s2_r, ref_s3_r;
   logic [DIV_W:0]           ref_cnt_r, loc_cnt_r;
   logic                     ref_evt_r, loc_evt_r;
   logic [DIV_W-1:0]         rate_cnt_r;
   logic [2:0]               pi_cnt_r;
   logic                     dsp_r, pi2_r, pi_r;
   logic signed [ERR_W-1:0]  pd_r, err_r;
   logic signed [WIDE_W-1:0] integ_r;
   logic signed [VOLT_W-1:0] filt_r, volt_r;
   logic signed [SD_W-1:0]   sd_r;
   logic [ACC_W-1:0]         phase_r;
   logic [STEP_W-1:0]        step_r;
   logic                     detector_overflow_flag_r, filter_input_sat_flag_r, integrator_sat_flag_r, filter_output_sat_flag_r;

   // reference edge seen only after the two-stage synchroniser
   logic ref_edge, ref_wrap, loc_wrap, dsp_end;
   assign ref_edge = ref_s2_r && !ref_s3_r; // see [RULE27]
   assign ref_wrap = pidp_div_end(ref_cnt_r, ref_div_setting);
   assign loc_wrap = pidp_div_end(loc_cnt_r, local_div_setting);
   assign dsp_end = rate_cnt_r == loop_rate_setting;

   // synchroniser for the asynchronous reference
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ref_s1_r <= 1'b0;
         ref_s2_r <= 1'b0;
         ref_s3_r <= 1'b0;
      end else if (ce) begin
         ref_s1_r <= ref_clk_in;
         ref_s2_r <= ref_s1_r; // see [RULE27]
         ref_s3_r <= ref_s2_r;
      end
   end

   // reference divider counts synchronised edges, period R+2
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ref_cnt_r <= '0;
         ref_evt_r <= 1'b0;
      end else if (ce) begin
         ref_evt_r <= ref_edge && reference_divider_enable && ref_wrap; // see [RULE14]
         if (ref_edge && reference_divider_enable) begin // see [RULE18]
            ref_cnt_r <= ref_wrap ? '0 : ref_cnt_r + 17'h1;
         end
      end
   end

   // local divider counts transmit clock cycles, period V+2
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         loc_cnt_r <= '0;
         loc_evt_r <= 1'b0;
      end else if (ce) begin
         loc_evt_r <= local_divider_enable && loc_wrap; // see [RULE15]
         if (local_divider_enable) begin
            loc_cnt_r <= loc_wrap ? '0 : loc_cnt_r + 17'h1;
         end
      end
   end

   // loop-rate and interpolator-rate strobes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rate_cnt_r <= '0;
         pi_cnt_r <= '0;
         dsp_r <= 1'b0;
         pi2_r <= 1'b0;
         pi_r <= 1'b0;
      end else if (ce) begin
         rate_cnt_r <= dsp_end ? '0 : rate_cnt_r + 16'h1; // see [RULE17]
         dsp_r <= dsp_end;
         pi2_r <= dsp_r;
         pi_cnt_r <= (pi_cnt_r == PI_DIV - 3'h1) ? '0 : pi_cnt_r + 3'h1;
         pi_r <= pi_cnt_r == PI_DIV - 3'h1;
      end
   end

   // detector: +1 per reference event, -1 per local event, restarted per loop
   logic signed [WIDE_W-1:0] pd_delta, pd_sum, pd_sat;
   assign pd_delta = (ref_evt_r == loc_evt_r) ? 48'sh0 : (ref_evt_r ? 48'sh1 : -48'sh1);
   assign pd_sum = (dsp_r ? 48'sh0 : WIDE_W'(pd_r)) + pd_delta; // see [RULE10]
   assign pd_sat = pidp_clamp(pd_sum, ERR_W);

   // detector keeps running through freeze and override
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pd_r <= '0;
         err_r <= '0;
         detector_overflow_flag_r <= 1'b0;
      end else if (ce) begin
         pd_r <= ERR_W'(pd_sat); // see [RULE26]
         if (dsp_r) err_r <= pd_r; // see [RULE10]
         detector_overflow_flag_r <= (pd_sat != pd_sum) || (detector_overflow_flag_r && !dsp_r); // see [RULE11]
      end
   end

   // gains clamped to their legal maximum, applied as shifts
   logic [GAIN_W-1:0]        g1_eff, g2_eff;
   logic signed [WIDE_W-1:0] prop_raw, int_raw, prop_c, int_c;
   logic signed [WIDE_W-1:0] integ_sum, integ_c, filt_sum, filt_c;
   logic                     ab_sat, int_sat, volt_sat, filt_upd;
   logic signed [VOLT_W-1:0] filt_nxt;
   assign g1_eff = (proportional_gain > G1_MAX) ? G1_MAX : proportional_gain; // see [RULE12]
   assign g2_eff = (integral_gain > G2_MAX) ? G2_MAX : integral_gain; // see [RULE13]
   assign prop_raw = WIDE_W'(err_r) <<< g1_eff; // see [RULE21]
   assign int_raw = WIDE_W'(err_r) <<< g2_eff;
   assign prop_c = pidp_clamp(prop_raw, AB_W);
   assign int_c = pidp_clamp(int_raw, AB_W);
   assign ab_sat = (prop_c != prop_raw) || (int_c != int_raw);
   assign integ_sum = integ_r + int_c;
   assign integ_c = pidp_clamp(integ_sum, INT_W);
   assign int_sat = integ_c != integ_sum;
   assign filt_sum = (prop_c + integ_c) >>> FILT_SHIFT;
   assign filt_c = pidp_clamp(filt_sum, VOLT_W);
   assign volt_sat = filt_c != filt_sum;
   assign filt_upd = pi2_r && !freeze; // see [RULE20]
   assign filt_nxt = filt_upd ? VOLT_W'(filt_c) : filt_r;

   // filter: freeze gates integrator and output; override only the output
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         integ_r <= '0;
         filt_r <= '0;
         volt_r <= '0;
      end else if (ce) begin
         if (filt_upd) integ_r <= integ_c;
         filt_r <= filt_nxt;
         volt_r <= offset_enable ? offset_value : filt_nxt; // see [RULE19]
      end
   end

   // saturation flags hold until the next loop strobe; a new hit wins
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         filter_input_sat_flag_r <= 1'b0;
         integrator_sat_flag_r <= 1'b0;
         filter_output_sat_flag_r <= 1'b0;
      end else if (ce) begin
         filter_input_sat_flag_r <= (pi2_r && ab_sat) || (filter_input_sat_flag_r && !dsp_r); // see [RULE11]
         integrator_sat_flag_r <= (filt_upd && int_sat) || (integrator_sat_flag_r && !dsp_r);
         filter_output_sat_flag_r <= (filt_upd && volt_sat) || (filter_output_sat_flag_r && !dsp_r);
      end
   end

   // first-order sigma-delta: positive voltage subtracts phase
   logic signed [WIDE_W-1:0] sd_sum, sd_adj;
   logic                     fire_dn, fire_up, do_step;
   logic [ACC_W-1:0]         phase_nxt;
   assign sd_sum = WIDE_W'(sd_r) + WIDE_W'(volt_r);
   assign fire_dn = sd_sum >= SD_HALF;
   assign fire_up = sd_sum < -SD_HALF;
   assign sd_adj = fire_dn ? sd_sum - SD_FULL : (fire_up ? sd_sum + SD_FULL : sd_sum);
   assign do_step = (fire_dn || fire_up) && (interp_step_size != 4'h0); // see [RULE16]
   assign phase_nxt = fire_dn ? phase_r - ACC_W'(interp_step_size)
                              : phase_r + ACC_W'(interp_step_size);

   // accumulator and step word update at the interpolator rate
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sd_r <= '0;
         phase_r <= '0;
         step_r <= '0;
      end else if (ce) begin
         if (pi_r) sd_r <= SD_W'(sd_adj);
         if (pi_r && do_step) phase_r <= phase_nxt;
         step_r <= (pi_r && do_step) ? {fire_dn, interp_step_size} : '0; // see [RULE5]
      end
   end

   // the written word is the phase before this update, so the first one is zero
   assign dev_if.req = pi_r; // see [RULE23]
   assign dev_if.addr = PI_ADDR;
   assign dev_if.wdata = {{(DATA_W - ACC_W){1'b0}}, phase_r};

   pidp_arbiter u_arb (
      .mclk                (mclk),
      .rst_n               (rst_n),
      .ce                  (ce),
      .arb_reset           (arb_reset),
      .access_req          (access_req),
      .user_port_enable    (user_port_enable),
      .user_port_write     (user_port_write),
      .user_port_addr      (user_port_addr),
      .user_port_wdata     (user_port_wdata),
      .cfg_port_ready_in   (cfg_port_ready_in),
      .cfg_port_enable_out (cfg_port_enable_out),
      .cfg_port_write_out  (cfg_port_write_out),
      .cfg_port_addr_out   (cfg_port_addr_out),
      .cfg_port_wdata_out  (cfg_port_wdata_out),
      .port_busy_out       (port_busy_out),
      .dev                 (dev_if.arb)
   );

   // read path is a straight wire; a register here would skew ready and data
   assign user_read_data = cfg_port_rdata_in; // see [RULE1]
   assign user_read_ready = cfg_port_ready_in; // see [RULE2]
   assign phase_step_out = step_r;
   assign error_out = err_r; // see [RULE7]
   assign volt_out = volt_r; // see [RULE8]
   assign accumulator_value_out = phase_r; // see [RULE9]
   assign accumulator_strobe_out = pi_r;
   assign filter_dac_strobe_out = pi2_r;
   assign loop_strobe_out = dsp_r;
   assign detector_overflow_flag = detector_overflow_flag_r;
   assign filter_input_sat_flag = filter_input_sat_flag_r;
   assign integrator_sat_flag = integrator_sat_flag_r;
   assign filter_output_sat_flag = filter_output_sat_flag_r;

   property p_reset_zero;
      @(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> error_out == '0 && phase_step_out == '0 && !dev_if.wdata[0];
   endproperty
   a_reset_zero: assert property (p_reset_zero) // see [RULE23]
      else $error("first outputs after reset not zero");

   property p_load_error;
      @(posedge mclk) disable iff (!rst_n)
      (ce && loop_strobe_out) |=> error_out == $past(pd_r) && pd_r >= -21'sh1 && pd_r <= 21'sh1;
   endproperty
   a_load_error: assert property (p_load_error) // see [RULE10]
      else $error("loop strobe did not load and clear the detector");

   property p_zero_step;
      @(posedge mclk) disable iff (!rst_n)
      (ce && interp_step_size == 4'h0) |=> phase_step_out == '0 && $stable(accumulator_value_out);
   endproperty
   a_zero_step: assert property (p_zero_step) // see [RULE16]
      else $error("zero step size produced a phase step");

   property p_override;
      @(posedge mclk) disable iff (!rst_n)
      (ce && offset_enable) |=> volt_out == $past(offset_value);
   endproperty
   a_override: assert property (p_override) // see [RULE19]
      else $error("offset override not applied");

   property p_live_after;
      @(posedge mclk) disable iff (!rst_n)
      (ce && !offset_enable) |=> volt_out == filt_r;
   endproperty
   a_live_after: assert property (p_live_after) // see [RULE26]
      else $error("filter output not shown without override");

   property p_freeze;
      @(posedge mclk) disable iff (!rst_n)
      (ce && freeze && filter_dac_strobe_out) |=> $stable(filt_r) && $stable(integ_r);
   endproperty
   a_freeze: assert property (p_freeze) // see [RULE20]
      else $error("filter moved while frozen");

   property p_pd_flag;
      @(posedge mclk) disable iff (!rst_n)
      (ce && detector_overflow_flag && !loop_strobe_out) |=> detector_overflow_flag;
   endproperty
   a_pd_flag: assert property (p_pd_flag) // see [RULE11]
      else $error("detector overflow flag dropped before loop strobe");

   property p_step_strobe;
      @(posedge mclk) disable iff (!rst_n)
      (phase_step_out != '0) |-> $past(accumulator_strobe_out) && $past(ce);
   endproperty
   a_step_strobe: assert property (p_step_strobe) // see [RULE5]
      else $error("phase step outside interpolator update");
endmodule // pidp_top

// ===== dv/pidp_xcvr_model.sv
// transceiver config port: answers an access after LAT cycles unless a new access restarts the count
module pidp_xcvr_model #(
   parameter int LAT = 3
) (
   input  wire logic                        mclk,
   input  wire logic                        en,
   input  wire logic [pidp_pkg::ADDR_W-1:0] addr,
   output logic                             rdy,
   output logic [pidp_pkg::DATA_W-1:0]      rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   int                          cnt_r = 0;
   logic [pidp_pkg::ADDR_W-1:0] addr_r = '0;
   initial rdy = 1'b0;
   initial rdata = 16'h0000;
   // data line toggles between answers so a stale value never looks valid
   always @(posedge mclk) begin
      rdy <= 1'b0;
      rdata <= ~rdata;
      if (en) begin
         cnt_r <= LAT;
         addr_r <= addr;
      end else if (cnt_r == 1) begin
         rdy <= 1'b1;
         rdata <= {addr_r[6:0], addr_r};
         cnt_r <= 0;
      end else if (cnt_r > 1) cnt_r <= cnt_r - 1;
   end
endmodule // pidp_xcvr_model

// ===== dv/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pidp_pkg::*;
   logic mclk = 0, rst_n = 0, ce = 1, ref_clk_in = 0, arb_reset = 0, access_req = 0;
   logic user_port_enable = 0, user_port_write = 0, offset_enable = 0, freeze = 0;
   logic [ADDR_W-1:0] user_port_addr = '0, cfg_port_addr_out;
   logic [DATA_W-1:0] user_port_wdata = '0, user_read_data, cfg_port_wdata_out, cfg_port_rdata_in;
   logic user_read_ready, port_busy_out, cfg_port_enable_out, cfg_port_write_out;
   logic cfg_port_ready_in, accumulator_strobe_out, filter_dac_strobe_out, loop_strobe_out;
   logic detector_overflow_flag, filter_input_sat_flag, integrator_sat_flag;
   logic filter_output_sat_flag;
   logic [STEP_W-1:0] phase_step_out;
   logic signed [ERR_W-1:0] error_out;
   logic signed [VOLT_W-1:0] volt_out, offset_value = '0;
   logic [ACC_W-1:0] accumulator_value_out;
   logic [GAIN_W-1:0] proportional_gain = 5'h04, integral_gain = 5'h01;
   logic [DIV_W-1:0] ref_div_setting = 16'h0003, local_div_setting = 16'h0005;
   logic [DIV_W-1:0] loop_rate_setting = 16'h0007;
   logic [SIZE_W-1:0] interp_step_size = 4'h1;
   logic local_divider_enable = 1, reference_divider_enable = 1;
   logic [RSVD_C_W-1:0] rsvd_c_in = '0;
   logic [RSVD_PN_W-1:0] rsvd_p_in = '0, rsvd_n_in = '0;
   int bad_count = 0, checks_done = 0, cyc = 0, n;

   pidp_top DUT (.*);
   pidp_xcvr_model xcvr (.mclk(mclk), .en(cfg_port_enable_out), .addr(cfg_port_addr_out),
                         .rdy(cfg_port_ready_in), .rdata(cfg_port_rdata_in));

   initial forever #4 mclk = ~mclk;
   // reference runs unrelated to mclk
   initial forever #37 ref_clk_in = ~ref_clk_in;
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // one strobe cycle on the user side, then look at the port one edge later
   task automatic user_access(input logic wr, input logic [ADDR_W-1:0] a);
      @(posedge mclk);
      user_port_enable <= 1'b1;
      user_port_write <= wr;
      user_port_addr <= a;
      user_port_wdata <= {a[3:0], 12'hc35};
      @(posedge mclk);
      user_port_enable <= 1'b0;
      user_port_write <= 1'b0;
      #1 check({cfg_port_enable_out, cfg_port_write_out, cfg_port_addr_out},
               {1'b1, wr, a});
      if (wr) check(cfg_port_wdata_out, {a[3:0], 12'hc35});
   endtask

   task automatic strobe_period();
      for (n = 0; n < 50 && loop_strobe_out !== 1'b1; n++) @(posedge mclk) #1;
      n = 0;
      do begin @(posedge mclk); #1; n++; end while (loop_strobe_out !== 1'b1 && n < 50);
      check(n, loop_rate_setting + 1);
      @(posedge mclk) #1 check(filter_dac_strobe_out, 1'b1);
   endtask

   initial begin
      repeat (7) @(posedge mclk);
      #1 check({port_busy_out, error_out, phase_step_out}, {1'b1, 26'h0});
      @(posedge mclk) rst_n <= 1'b1;
      strobe_period();
      @(posedge mclk) access_req <= 1'b1;
      for (n = 0; n < 50 && port_busy_out !== 1'b0; n++) @(posedge mclk) #1;
      check(port_busy_out, 1'b0);
      user_access(1'b1, 9'h0a3);
      user_access(1'b0, 9'h1c5);
      for (n = 0; n < 20 && user_read_ready !== 1'b1; n++) @(posedge mclk) #1;
      check({user_read_ready, user_read_data}, {1'b1, 16'h8bc5});
      // freeze across the arbiter reset: detector and strobes must keep going
      @(posedge mclk);
      arb_reset <= 1'b1;
      access_req <= 1'b0;
      freeze <= 1'b1;
      @(posedge mclk) arb_reset <= 1'b0;
      @(posedge mclk) #1 check(port_busy_out, 1'b1);
      strobe_period();
      @(posedge mclk);
      freeze <= 1'b0;
      offset_value <= 22'sh0abcde;
      offset_enable <= 1'b1;
      @(posedge mclk) #1 check(volt_out, 22'sh0abcde);
      // positive offset walks the phase down, one step of size 1 at a time
      for (n = 0; n < 60 && phase_step_out === 5'h00; n++) @(posedge mclk) #1;
      check({phase_step_out, accumulator_value_out}, {5'h11, 8'hff});
      @(posedge mclk) interp_step_size <= 4'h0;
      repeat (40) @(posedge mclk);
      #1 check({phase_step_out, accumulator_value_out}, {5'h00, 8'hff});
      check({detector_overflow_flag, filter_input_sat_flag, integrator_sat_flag,
             filter_output_sat_flag}, 4'h0);
      stop_test();
   end
endmodule // testbench
